/* shared/oms_pkg.sv */
// Purpose: constants and carrier types for the operating mode switch block
// Assumes: 32-bit classic Wishbone register bus, word aligned offsets
// Notes: register offsets are byte addresses
package oms_pkg;
   // bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // register byte offsets
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_ROOT = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_FAR = 8'h0C;
   localparam logic [7:0] OFF_SEG = 8'h10;
   localparam logic [7:0] OFF_INT = 8'h14;
   localparam logic [7:0] OFF_TBASE = 8'h18;
   // field positions
   localparam int unsigned PROT_EN_BIT = 0;
   localparam int unsigned PAGING_EN_BIT = 31;
   localparam int unsigned INT_EN_BIT = 0;
   localparam int unsigned SEG_IDX_LSB = 28;
   localparam int unsigned SEG_ATTR_LSB = 20;
   localparam int unsigned SEG_USABLE_BIT = 16;
   // values after reset and after a far transfer
   localparam logic [31:0] RST_CS_BASE = 32'hFFFF0000;
   localparam logic [31:0] RST_INSTR_PTR = 32'h0000FFF0;
   localparam logic [31:0] RST_FETCH_ADDR = 32'hFFFFFFF0;
   localparam logic [31:0] RST_ROOT = 32'h00000000;
   localparam logic [15:0] RST_SELECTOR = 16'h0000;
   localparam logic [1:0] ENTRY_PRIV_LEVEL = 2'h0;
   localparam logic [31:0] FAR_INSTR_PTR = 32'h00000000;
   // real-address mode access rights
   localparam logic [7:0] REAL_DATA_ATTR = 8'h93;
   localparam logic [7:0] REAL_CODE_ATTR = 8'h9B;
   // segment cache geometry
   localparam int unsigned SEG_CNT = 6;
   localparam int unsigned SEG_IDX_W = 3;
   localparam logic [2:0] CS_IDX = 3'h1;
   // one cached segment register
   typedef struct packed {
      logic [15:0] selector;
      logic [7:0] attr;
      logic usable;
   } oms_seg_t;
   // status word carrier
   typedef struct packed {
      logic [1:0] priv_level;
      logic int_en;
      logic far_pend;
      logic paging;
      logic prot;
   } oms_status_t;
   // operating mode, gray coded along the switch path
   typedef enum logic [1:0] {
      MODE_REAL = 2'b00,
      MODE_TO_PROT = 2'b01,
      MODE_PROT = 2'b11,
      MODE_TO_REAL = 2'b10
   } oms_mode_t;
endpackage

/* rtl/oms_seg_cache.sv */
// Purpose: cached segment registers with selector, attributes, usable flag
// Assumes: one write port, combinational read of flip-flop contents
// Notes: entries keep their contents across mode switches
`timescale 1ns/1ps
`default_nettype none
module oms_seg_cache #(
   parameter int unsigned SEG_CNT = oms_pkg::SEG_CNT
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [2:0] wr_idx_i,
   input wire logic [15:0] wr_sel_i,
   input wire logic [7:0] wr_attr_i,
   input wire logic prot_i,
   // read port
   input wire logic [2:0] rd_idx_i,
   output oms_pkg::oms_seg_t rd_o
);
   oms_pkg::oms_seg_t entry_reg [SEG_CNT];
   oms_pkg::oms_seg_t wr_entry;
   wire logic null_sel;
   wire logic rd_valid;

   // null selector in protected mode leaves the register unusable
   assign null_sel = prot_i && (wr_sel_i[15:2] == 14'h0000); // [R19]
   assign wr_entry = '{selector: wr_sel_i, attr: wr_attr_i,
                       usable: !null_sel};
   assign rd_valid = (32'(rd_idx_i) < SEG_CNT);
   assign rd_o = rd_valid ? entry_reg[rd_idx_i] : '0;

   // one flop group per entry, untouched unless addressed
   for (genvar g = 0; g < SEG_CNT; g++) begin : g_entry
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            entry_reg[g] <= '{selector: oms_pkg::RST_SELECTOR,
                              attr: oms_pkg::REAL_DATA_ATTR, usable: 1'b1};
         end else if (wr_en_i && (32'(wr_idx_i) == g)) begin
            entry_reg[g] <= wr_entry; // [R19]
         end
      end
   end

   // an entry holds unless written
   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      !wr_en_i |=> (rd_o == $past(rd_o)) || (rd_idx_i != $past(rd_idx_i));
   endproperty
   AST_SEG_HOLD: assert property (p_hold) // [R19]
      else $error("segment entry changed without a write");
   AST_SEG_NULL: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_en_i && null_sel && (rd_idx_i == wr_idx_i) && (32'(wr_idx_i) < SEG_CNT)
      ##1 (rd_idx_i == $past(rd_idx_i)) |-> !rd_o.usable) // [R19]
      else $error("null selector left the segment usable");
endmodule
`default_nettype wire

/* rtl/oms_mode_ctrl.sv */
// Purpose: operating mode control with protection, paging and segment state
// Assumes: classic Wishbone slave, synchronous active high reset, 20 MHz
// Notes: ack comes one cycle after the request, writes land on the ack edge
// Functional notes
// R1: protection flag set enters protected, privilege zero
// R2: protection flag is bit zero of mode
// R3: one write may also set paging flag
// R4: paging flag clear after reset
// R5: software masks interrupts before switching
// R6: software loads global table pointer first
// R7: far transfer after mode write flushes prefetch
// R8: switch code runs from identity mapped page
// R9: segment registers keep contents; far reloads code
// R10: code base retained until far transfer
// R11: software reloads data and stack segments
// R12: software loads task register if needed
// R13: software loads interrupt table pointer next
// R14: software re-enables interrupts, board unblocks nonmaskable
// R15: protection flag clear returns to real mode
// R16: root pointer write flushes translation buffer
// R17: software enters readable 64K limit code
// R18: software loads real-style data descriptors
// R19: unreloaded segments keep attributes; null unusable
// R20: software places interrupt table below 1M
// R21: far jump to real reloads code base, rights
// R22: return sequence code in one identity page
// R23: first fetch after reset at top address
// R24: maskable off after reset, nonmaskable live
// R25: board holds nonmaskable pin until handler
// R26: root pointer holds translation table base
`timescale 1ns/1ps
`default_nettype none
module oms_mode_ctrl (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // interrupt pins
   input wire logic maskable_interrupt_request_i,
   input wire logic nmi_pin_i,
   output logic maskable_irq_o,
   output logic nmi_req_o,
   // mode state
   output logic protected_o,
   output logic paging_o,
   output logic [1:0] current_privilege_level_o,
   output logic far_pending_o,
   output logic [31:0] cs_base_o,
   output logic [31:0] fetch_addr_o,
   output logic [31:0] translation_root_pointer_o,
   // flush pulses
   output logic queue_flush_o,
   output logic tlb_flush_o
);
   // byte lane merge of a write onto the current word
   function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] sel);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction

   // word address match
   function automatic logic word_hit(input logic [7:0] adr,
                                     input logic [7:0] off);
      return adr[7:2] == off[7:2];
   endfunction

   oms_pkg::oms_mode_t mode_reg, mode_next;
   oms_pkg::oms_status_t status_w;
   oms_pkg::oms_seg_t seg_rd;
   logic ack_reg;
   logic [31:0] rd_dat_reg;
   logic prot_reg, prot_next;
   logic paging_reg, paging_next;
   logic [1:0] priv_reg, priv_next;
   logic int_en_reg;
   logic [31:0] root_reg;
   logic [31:0] tbase_reg;
   logic [31:0] cs_base_reg, cs_base_next;
   logic [31:0] ip_reg, ip_next;
   logic [31:0] fetch_reg;
   logic [15:0] cs_sel_reg;
   logic [2:0] seg_idx_reg;
   logic qflush_reg;
   logic tflush_reg;
   logic [1:0] nmi_sync_reg;
   logic [1:0] mirq_sync_reg;
   wire logic req;
   wire logic wr_fire;
   wire logic [31:0] rd_mux;
   wire logic [31:0] wr_word;
   wire logic mode_wr, root_wr, far_wr, seg_wr, int_wr, tbase_wr;
   wire logic wr_prot, wr_paging;
   wire logic far_legal;
   wire logic [31:0] far_base;
   wire logic [7:0] far_attr;
   wire logic cache_wr;
   wire logic [2:0] cache_idx;
   wire logic [15:0] cache_sel;
   wire logic [7:0] cache_attr;

   // bus handshake: ack one cycle after request, write on the ack edge
   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
   assign mode_wr = wr_fire && word_hit(wb_adr_i, oms_pkg::OFF_MODE);
   assign root_wr = wr_fire && word_hit(wb_adr_i, oms_pkg::OFF_ROOT);
   assign far_wr = wr_fire && word_hit(wb_adr_i, oms_pkg::OFF_FAR);
   assign seg_wr = wr_fire && word_hit(wb_adr_i, oms_pkg::OFF_SEG);
   assign int_wr = wr_fire && word_hit(wb_adr_i, oms_pkg::OFF_INT);
   assign tbase_wr = wr_fire && word_hit(wb_adr_i, oms_pkg::OFF_TBASE);
   assign wr_word = be_merge(rd_mux, wb_dat_i, wb_sel_i);
   assign wr_prot = wr_word[oms_pkg::PROT_EN_BIT]; // [R2]
   assign wr_paging = wr_word[oms_pkg::PAGING_EN_BIT]; // [R3]

   // status word and read selection, unmapped reads return zero
   assign status_w = '{priv_level: priv_reg, int_en: int_en_reg,
                       far_pend: far_pending_o, paging: paging_reg,
                       prot: prot_reg};
   assign rd_mux =
      word_hit(wb_adr_i, oms_pkg::OFF_MODE) ?
         {paging_reg, 30'h00000000, prot_reg} :
      word_hit(wb_adr_i, oms_pkg::OFF_ROOT) ? root_reg :
      word_hit(wb_adr_i, oms_pkg::OFF_STATUS) ? {26'h0000000, status_w} :
      word_hit(wb_adr_i, oms_pkg::OFF_FAR) ? {16'h0000, cs_sel_reg} :
      word_hit(wb_adr_i, oms_pkg::OFF_SEG) ?
         {1'b0, seg_idx_reg, seg_rd.attr, 3'h0, seg_rd.usable,
          seg_rd.selector} :
      word_hit(wb_adr_i, oms_pkg::OFF_INT) ? {31'h00000000, int_en_reg} :
      word_hit(wb_adr_i, oms_pkg::OFF_TBASE) ? tbase_reg :
      32'h00000000;

   // bus answer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rd_dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= req;
         if (req) begin
            rd_dat_reg <= rd_mux;
         end
      end
   end

   // mode sequencer: a switch waits for the far transfer
   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         oms_pkg::MODE_REAL: begin
            if (mode_wr && wr_prot) begin
               mode_next = oms_pkg::MODE_TO_PROT; // [R1]
            end
         end
         oms_pkg::MODE_TO_PROT: begin
            if (far_wr) begin
               mode_next = oms_pkg::MODE_PROT; // [R7]
            end else if (mode_wr && !wr_prot) begin
               mode_next = oms_pkg::MODE_REAL; // [R15]
            end
         end
         oms_pkg::MODE_PROT: begin
            if (mode_wr && !wr_prot) begin
               mode_next = oms_pkg::MODE_TO_REAL; // [R15]
            end
         end
         oms_pkg::MODE_TO_REAL: begin
            if (far_wr) begin
               mode_next = oms_pkg::MODE_REAL; // [R21]
            end else if (mode_wr && wr_prot) begin
               mode_next = oms_pkg::MODE_PROT;
            end
         end
      endcase
   end
   assign far_legal = (mode_reg == oms_pkg::MODE_TO_PROT) ||
                      (mode_reg == oms_pkg::MODE_TO_REAL);
   assign far_pending_o = far_legal;

   // flags and privilege level
   always_comb begin
      prot_next = prot_reg;
      paging_next = paging_reg;
      priv_next = priv_reg;
      if (mode_wr) begin
         prot_next = wr_prot; // [R1] [R15]
         paging_next = wr_paging; // [R3]
         if (wr_prot && !prot_reg) begin
            priv_next = oms_pkg::ENTRY_PRIV_LEVEL; // [R1]
         end
      end
      if (far_wr && prot_reg) begin
         priv_next = wr_word[1:0];
      end
      if (!prot_next) begin
         priv_next = oms_pkg::ENTRY_PRIV_LEVEL;
      end
   end

   // far transfer target: real uses paragraph, protected uses staged base
   assign far_base = prot_reg ? tbase_reg
                              : {12'h000, wr_word[15:0], 4'h0}; // [R21]
   assign far_attr = prot_reg ? wr_word[27:20]
                              : oms_pkg::REAL_CODE_ATTR; // [R21]

   // code base is only changed by a far transfer
   always_comb begin
      cs_base_next = cs_base_reg; // [R10]
      ip_next = ip_reg;
      if (far_wr) begin
         cs_base_next = far_base; // [R9]
         ip_next = oms_pkg::FAR_INSTR_PTR;
      end
   end

   // mode, flag and code segment registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= oms_pkg::MODE_REAL;
         prot_reg <= 1'b0;
         paging_reg <= 1'b0; // [R4]
         priv_reg <= oms_pkg::ENTRY_PRIV_LEVEL;
         cs_base_reg <= oms_pkg::RST_CS_BASE;
         ip_reg <= oms_pkg::RST_INSTR_PTR;
         fetch_reg <= oms_pkg::RST_FETCH_ADDR; // [R23]
         cs_sel_reg <= oms_pkg::RST_SELECTOR;
      end else begin
         mode_reg <= mode_next;
         prot_reg <= prot_next;
         paging_reg <= paging_next;
         priv_reg <= priv_next;
         cs_base_reg <= cs_base_next;
         ip_reg <= ip_next;
         fetch_reg <= cs_base_next + ip_next; // [R10]
         if (far_wr) begin
            cs_sel_reg <= wr_word[15:0]; // [R9]
         end
      end
   end

   // root pointer, staged base, interrupt enable and flush pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         root_reg <= oms_pkg::RST_ROOT;
         tbase_reg <= 32'h00000000;
         int_en_reg <= 1'b0; // [R24]
         qflush_reg <= 1'b0;
         tflush_reg <= 1'b0;
         seg_idx_reg <= 3'h0;
      end else begin
         if (root_wr) begin
            root_reg <= wr_word; // [R26]
         end
         if (tbase_wr) begin
            tbase_reg <= wr_word;
         end
         if (int_wr) begin
            int_en_reg <= wr_word[oms_pkg::INT_EN_BIT];
         end
         if (seg_wr) begin
            seg_idx_reg <= wr_word[30:28];
         end
         qflush_reg <= far_wr && far_legal; // [R7] [R21]
         tflush_reg <= root_wr; // [R16]
      end
   end

   // segment cache port: the code entry is written only by far transfers
   assign cache_wr = far_wr || (seg_wr && (wr_word[30:28] != oms_pkg::CS_IDX));
   assign cache_idx = far_wr ? oms_pkg::CS_IDX : wr_word[30:28]; // [R9]
   assign cache_sel = wr_word[15:0];
   assign cache_attr = far_wr ? far_attr :
                       prot_reg ? wr_word[27:20] : oms_pkg::REAL_DATA_ATTR;

   oms_seg_cache #(
      .SEG_CNT(oms_pkg::SEG_CNT)
   ) u_seg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(cache_wr),
      .wr_idx_i(cache_idx),
      .wr_sel_i(cache_sel),
      .wr_attr_i(cache_attr),
      .prot_i(prot_reg),
      .rd_idx_i(seg_idx_reg),
      .rd_o(seg_rd)
   );

   // pin synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nmi_sync_reg <= 2'b00;
         mirq_sync_reg <= 2'b00;
      end else begin
         nmi_sync_reg <= {nmi_sync_reg[0], nmi_pin_i};
         mirq_sync_reg <= {mirq_sync_reg[0], maskable_interrupt_request_i};
      end
   end

   // outputs
   assign maskable_irq_o = int_en_reg && mirq_sync_reg[1]; // [R24]
   assign nmi_req_o = nmi_sync_reg[1]; // [R24]
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rd_dat_reg;
   assign protected_o = prot_reg;
   assign paging_o = paging_reg;
   assign current_privilege_level_o = priv_reg;
   assign cs_base_o = cs_base_reg;
   assign fetch_addr_o = fetch_reg;
   assign translation_root_pointer_o = root_reg;
   assign queue_flush_o = qflush_reg;
   assign tlb_flush_o = tflush_reg;

   // checks
   AST_ENTER_PROT: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_wr && wr_prot && !prot_reg |=>
      protected_o && (current_privilege_level_o == 2'h0)) // [R1]
      else $error("protected entry without privilege zero");
   AST_FLAG_BIT0: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_wr |=> protected_o == $past(wr_word[0])) // [R2]
      else $error("protection flag not taken from bit zero");
   AST_PAGING_SAME: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_wr && wr_prot && wr_paging |=> protected_o && paging_o) // [R3]
      else $error("paging not enabled with protection");
   AST_RESET_STATE: assert property (@(posedge clk_i)
      $past(rst_i) |-> !paging_o && !protected_o &&
      (fetch_addr_o == 32'hFFFFFFF0) && !maskable_irq_o) // [R4] [R23]
      else $error("reset state wrong");
   AST_QUEUE_FLUSH: assert property (@(posedge clk_i) disable iff (rst_i)
      far_wr && far_legal |=> queue_flush_o ##1 !queue_flush_o) // [R7]
      else $error("queue flush pulse missing");
   AST_BASE_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_wr && !far_wr |=> $stable(cs_base_o)) // [R10]
      else $error("code base changed by mode write");
   // a clear from protected mode waits for the far jump; an abandoned entry
   // drops straight back to real with nothing pending
   AST_LEAVE_PROT: assert property (@(posedge clk_i) // [R15]
      disable iff (rst_i) mode_wr && !wr_prot |=> !protected_o &&
      far_pending_o == (($past(mode_reg) == oms_pkg::MODE_PROT) ||
                        ($past(mode_reg) == oms_pkg::MODE_TO_REAL)))
      else $error("return to real mode wrong");
   AST_TLB_FLUSH: assert property (@(posedge clk_i) disable iff (rst_i)
      root_wr |=> tlb_flush_o && (translation_root_pointer_o == $past(wr_word))
      ##1 !tlb_flush_o || $past(root_wr)) // [R16] [R26]
      else $error("translation flush or root load wrong");
   AST_REAL_CS: assert property (@(posedge clk_i) disable iff (rst_i)
      far_wr && !prot_reg |=>
      cs_base_o == {12'h000, $past(wr_word[15:0]), 4'h0}) // [R21]
      else $error("real mode code base not reloaded");
   AST_NMI_LIVE: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(nmi_pin_i, 2) && !$past(rst_i, 2) && !$past(rst_i) |->
      nmi_req_o) // [R24]
      else $error("nonmaskable request blocked");
   COV_ENTER: cover property (@(posedge clk_i) disable iff (rst_i)
      mode_reg == oms_pkg::MODE_TO_PROT ##1 mode_reg == oms_pkg::MODE_PROT);
   COV_RETURN: cover property (@(posedge clk_i) disable iff (rst_i)
      mode_reg == oms_pkg::MODE_TO_REAL ##1 mode_reg == oms_pkg::MODE_REAL);
   COV_PAGING: cover property (@(posedge clk_i) disable iff (rst_i)
      mode_wr && wr_prot && wr_paging);
   COV_TLB: cover property (@(posedge clk_i) disable iff (rst_i) tlb_flush_o);
endmodule
`default_nettype wire

/* tb/oms_board_model.sv */
// Purpose: board gating of the nonmaskable pin in front of the mode block
// Assumes: gate flag cleared by reset, set once a handler is installed
// Notes: boot software itself is played by the bench task sequence
`timescale 1ns/1ps
`default_nettype none
module oms_board_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // raw source and software unblock
   input wire logic nmi_src_i,
   input wire logic unblock_i,
   // gated pin toward the block
   output logic nmi_pin_o
);
   logic gate_reg;
   // gate flag: cleared on reset, set by software when ready
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gate_reg <= 1'b0;
      end else if (unblock_i) begin
         gate_reg <= 1'b1;
      end
   end
   // pin stays low until the handler exists
   assign nmi_pin_o = nmi_src_i & gate_reg;
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench for the operating mode control block
// Assumes: one-cycle ack, effects visible the cycle after the ack
// Notes: tasks drive classic single Wishbone cycles at rising edges
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat_w = 32'h0, dat_r, q;
   logic ack, irq_pin = 1'b0, nmi_raw = 1'b1, unblock = 1'b0, nmi_pin;
   logic irq, nmi, prot, pg, fpend, qfl, tfl;
   logic [1:0] priv;
   logic [31:0] cs_base, fetch, root;
   int mismatches = 0;
   int n_compared = 0;
   // clock of 50 ns period
   always #25 clk_i = ~clk_i;
   oms_board_model i_oms_board_model (.clk_i(clk_i), .rst_i(rst_i),
      .nmi_src_i(nmi_raw), .unblock_i(unblock), .nmi_pin_o(nmi_pin));
   oms_mode_ctrl i_oms_mode_ctrl (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .maskable_interrupt_request_i(irq_pin), .nmi_pin_i(nmi_pin),
      .maskable_irq_o(irq), .nmi_req_o(nmi), .protected_o(prot),
      .paging_o(pg), .current_privilege_level_o(priv),
      .far_pending_o(fpend), .cs_base_o(cs_base), .fetch_addr_o(fetch),
      .translation_root_pointer_o(root), .queue_flush_o(qfl),
      .tlb_flush_o(tfl));
   // verdict and end of run
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one comparison
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat_w <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         $display("FAIL wb_ack_o exp 1 got 0");
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      wb(1'b1, a, d, x);
   endtask
   // read and compare
   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      logic [31:0] x;
      wb(1'b0, a, 32'h0, x);
      chk(nm, e, x);
   endtask
   // one-cycle pulse seen after the write edge, gone a cycle later
   task automatic pulse(input string nm, input logic which);
      @(negedge clk_i);
      chk(nm, 1'b1, which ? qfl : tfl);
      @(negedge clk_i);
      chk(nm, 1'b0, which ? qfl : tfl);
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (4000) @(posedge clk_i);
      mismatches++;
      summarize();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("cs_base", 32'hFFFF0000, cs_base);
      chk("fetch", 32'hFFFFFFF0, fetch);
      chk("paging", 1'b0, pg);
      rdc("status", 8'h08, 32'h0);
      // nonmaskable stays live but gated until a handler exists
      repeat (4) @(negedge clk_i);
      chk("nmi_gated", 1'b0, nmi);
      @(posedge clk_i);
      unblock <= 1'b1;
      repeat (4) @(negedge clk_i);
      chk("nmi_req", 1'b1, nmi);
      @(posedge clk_i);
      irq_pin <= 1'b1;
      repeat (4) @(negedge clk_i);
      chk("irq_masked", 1'b0, irq);
      wr(8'h14, 32'h1);
      repeat (3) @(negedge clk_i);
      chk("irq_on", 1'b1, irq);
      wr(8'h14, 32'h0);
      @(negedge clk_i);
      chk("irq_off", 1'b0, irq);
      // root pointer load and translation flush
      wr(8'h04, 32'h00012000);
      pulse("tlb_flush", 1'b0);
      chk("root", 32'h00012000, root);
      // enter protected mode with paging in one write
      wr(8'h00, 32'h80000001);
      @(negedge clk_i);
      chk("prot", 1'b1, prot);
      chk("paging_on", 1'b1, pg);
      chk("priv", 2'h0, priv);
      chk("cs_kept", 32'hFFFF0000, cs_base);
      rdc("status_p", 8'h08, 32'h07);
      // far transfer reloads code base and flushes the queue
      wr(8'h18, 32'h00100000);
      @(negedge clk_i);
      chk("far_wait", 1'b1, fpend);
      wr(8'h0C, 32'h00000008);
      pulse("q_flush", 1'b1);
      chk("cs_new", 32'h00100000, cs_base);
      chk("fetch_new", 32'h00100000, fetch);
      chk("far_done", 1'b0, fpend);
      rdc("code_sel", 8'h0C, 32'h00000008);
      // segment cache: null selector unusable, live one usable
      wr(8'h10, 32'h39300000);
      // same entry again while it is the one read back
      wr(8'h10, 32'h39300003);
      rdc("seg_null", 8'h10, 32'h39300003);
      wr(8'h10, 32'h29200010);
      rdc("seg_live", 8'h10, 32'h29210010);
      // interrupts back on in protected mode, masked again before leaving
      wr(8'h14, 32'h1);
      @(negedge clk_i);
      chk("irq_prot", 1'b1, irq);
      wr(8'h14, 32'h0);
      // return to real mode, then clear the root
      wr(8'h00, 32'h00000000);
      @(negedge clk_i);
      chk("real", 1'b0, prot);
      chk("paging_off", 1'b0, pg);
      chk("far_wait_r", 1'b1, fpend);
      wr(8'h04, 32'h00000000);
      pulse("tlb_zero", 1'b0);
      rdc("seg_kept", 8'h10, 32'h29210010);
      wr(8'h0C, 32'h00001234);
      pulse("q_flush_r", 1'b1);
      chk("cs_real", 32'h00012340, cs_base);
      chk("fetch_real", 32'h00012340, fetch);
      // abandoned switch: clearing before the far jump goes straight to real
      wr(8'h00, 32'h00000001);
      wr(8'h00, 32'h00000000);
      @(negedge clk_i);
      chk("abandon_prot", 1'b0, prot);
      chk("abandon_far", 1'b0, fpend);
      rdc("unmapped", 8'h40, 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
